// file: core/contact_io_pkg.sv
// Purpose: Constants and types for the contact input/output function unit.
// Assumes: 50 MHz system clock, Wishbone classic register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
//
// Contract
// - Contact output follows one selected function
// - Alarm functions allow normally open or closed
// - Closed sense opens contact on active signal
// - General alarm asserts on any error present
// - Empty pipe forces alarm current, stops totals
// - Direction mode shows forward or reverse flow
// - No function never asserts the contact outside the contact test
// - Upper limit asserts above upper setpoint
// - Lower limit asserts below lower setpoint
// - Window asserts above upper or below lower
// - Swapped setpoints assert between the two
// - Input has one function; stop absent with HART
// - Zero return kills current, pulse; display stays
// - Reset input clears both totals and overflows
// - Stop input halts integration, shows stop
// - Input function none ignores the contact
// - Pulse and contact tests detach outputs until cancel
// - Pulse test is 1 Hz, 500 ms wide
// - Contact test toggles on each key command
// - Simulation drives outputs from 1 % value
package contact_io_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] REG_OUT_CFG = 8'h00;   // Output function, sense
    localparam logic [7:0] REG_IN_CFG = 8'h04;    // Input function
    localparam logic [7:0] REG_UPPER = 8'h08;     // Upper setpoint
    localparam logic [7:0] REG_LOWER = 8'h0c;     // Lower setpoint
    localparam logic [7:0] REG_CHECK = 8'h10;     // Self check control
    localparam logic [7:0] REG_SIM = 8'h14;       // Simulated flow percent
    localparam logic [7:0] REG_STATUS = 8'h18;    // Live status, read only

    // Field positions
    localparam int OUT_FN_LSB = 0;                // 3-bit output function
    localparam int OUT_NC_BIT = 4;                // 1 = normally closed
    localparam int IN_FN_LSB = 0;                 // 2-bit input function
    localparam int CHK_MODE_LSB = 0;              // 2-bit self check mode
    localparam int CHK_CANCEL_BIT = 4;            // Write 1 to cancel
    localparam int CHK_KEY_BIT = 5;               // Write 1 = step/data key

    // Reset values
    localparam logic [2:0] OUT_FN_RST = 3'h3;     // No function
    localparam logic [1:0] IN_FN_RST = 2'h3;      // No function
    localparam logic [7:0] SIM_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TEST_PERIOD_MS = 1000;         // 1 Hz pulse test
    localparam int TEST_WIDTH_MS = 500;
    localparam int TEST_PERIOD_CYC = CLK_HZ / 1000 * TEST_PERIOD_MS;
    localparam int TEST_WIDTH_CYC = CLK_HZ / 1000 * TEST_WIDTH_MS;

    ////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [2:0] {
        OUT_GEN_ALARM = 3'h0,
        OUT_EMPTY_PIPE = 3'h1,
        OUT_DIRECTION = 3'h2,
        OUT_NONE = 3'h3,
        OUT_UPPER = 3'h4,
        OUT_LOWER = 3'h5,
        OUT_WINDOW = 3'h6
    } out_fn_type;

    typedef enum logic [1:0] {
        IN_ZERO_RETURN = 2'h0,
        IN_TOT_RESET = 2'h1,
        IN_TOT_STOP = 2'h2,
        IN_NONE = 2'h3
    } in_fn_type;

    // Self check modes; Gray order along idle -> pulse -> contact -> sim
    typedef enum logic [1:0] {
        CHK_IDLE = 2'b00,
        CHK_PULSE = 2'b01,
        CHK_CONTACT = 2'b11,
        CHK_SIM = 2'b10
    } chk_type;

endpackage

// file: core/contact_io_unit.sv
// Purpose: Switch-contact output and contact input function unit.
// Assumes: Inputs synchronous to clk_sys; flow value signed percent.
// Notes: Totalizer and current output logic lie outside; this unit
// Notes: only drives their control strobes.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module contact_io_unit
    import contact_io_pkg::*;
#(
    parameter int FLOW_W = 16,
    parameter int PERIOD_CYC = TEST_PERIOD_CYC,
    parameter int WIDTH_CYC = TEST_WIDTH_CYC,
    parameter bit HART_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Measurement side
    input wire logic flow_valid,
    input wire logic signed [FLOW_W-1:0] flow_rate,
    input wire logic flow_reverse,
    input wire logic [11:0] error_flags,
    input wire logic empty_pipe_en,
    input wire logic empty_pipe_det,
    // Field contacts
    input wire logic contact_input,
    output logic switch_contact_output,
    // Controls to output and totalizer stages
    output logic current_alarm,
    output logic outputs_off,
    output logic outputs_detached,
    output logic tot_halt,
    output logic tot_clear,
    output logic stop_display,
    output logic empty_pipe_error,
    output logic test_pulse,
    output logic sim_active,
    output logic signed [FLOW_W-1:0] out_flow
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [2:0] out_fn_r;                 // Selected output function
    logic nc_r;                           // Contact sense
    logic [1:0] in_fn_r;                  // Selected input function
    logic signed [FLOW_W-1:0] upper_r;    // Upper setpoint
    logic signed [FLOW_W-1:0] lower_r;    // Lower setpoint
    logic signed [7:0] sim_r;             // Simulated flow in 1 % steps
    chk_type chk_r;                       // Self check state
    logic toggle_r;                       // Contact test state
    logic signal_r;                       // Selected signal, registered
    logic [31:0] pcnt_r;                  // Pulse test counter
    logic in_prev_r;                      // Contact input history
    logic wr;
    logic alarm_type;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    // Bus acknowledge: one cycle after strobe, drops next cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    // Configuration writes; only the low lane carries function fields
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_fn_r <= OUT_FN_RST;
            nc_r <= 1'b0;
            in_fn_r <= IN_FN_RST;
            upper_r <= '0;
            lower_r <= '0;
            sim_r <= SIM_RST;
        end else if (wr) begin
            unique case (wb_adr_i)
                REG_OUT_CFG: begin
                    // Codes beyond the table fall back to no function
                    if (wb_dat_i[OUT_FN_LSB+:3] <= 3'h6) begin
                        out_fn_r <= wb_dat_i[OUT_FN_LSB+:3];
                    end else begin
                        out_fn_r <= OUT_NONE;
                    end
                    nc_r <= wb_dat_i[OUT_NC_BIT];
                end
                REG_IN_CFG: begin
                    // Totalizer stop is refused in the HART build
                    if (HART_VARIANT &&
                        wb_dat_i[IN_FN_LSB+:2] == IN_TOT_STOP) begin
                        in_fn_r <= IN_NONE;
                    end else begin
                        in_fn_r <= wb_dat_i[IN_FN_LSB+:2];
                    end
                end
                REG_UPPER: upper_r <= wb_dat_i[FLOW_W-1:0];
                REG_LOWER: lower_r <= wb_dat_i[FLOW_W-1:0];
                REG_SIM: sim_r <= wb_dat_i[7:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Self check state: entered by write, left only by cancel
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chk_r <= CHK_IDLE;
        end else if (wr && wb_adr_i == REG_CHECK) begin
            if (wb_dat_i[CHK_CANCEL_BIT]) begin
                chk_r <= CHK_IDLE;
            end else if (chk_r == CHK_IDLE) begin
                chk_r <= chk_type'(wb_dat_i[CHK_MODE_LSB+:2]);
            end
        end
    end

    // Contact test toggles on each key write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            toggle_r <= 1'b0;
        end else if (chk_r != CHK_CONTACT) begin
            toggle_r <= 1'b0;
        end else if (wr && wb_adr_i == REG_CHECK &&
                     wb_dat_i[CHK_KEY_BIT]) begin
            toggle_r <= ~toggle_r;
        end
    end

    // Pulse test generator, free running only during that test
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pcnt_r <= '0;
        end else if (chk_r != CHK_PULSE || pcnt_r == 32'(PERIOD_CYC - 1)) begin
            pcnt_r <= '0;
        end else begin
            pcnt_r <= pcnt_r + 32'h1;
        end
    end

    assign test_pulse = (chk_r == CHK_PULSE) &&
                        (pcnt_r < 32'(WIDTH_CYC));

    ////////////////////////////////////////////////////////////////////////
    // Flow source: simulated value replaces the measurement
    assign sim_active = (chk_r == CHK_SIM);
    always_comb begin
        if (sim_active) begin
            out_flow = FLOW_W'(sim_r);
        end else begin
            out_flow = flow_rate;
        end
    end

    // Selected signal, refreshed on every new measurement
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            signal_r <= 1'b0;
        end else if (flow_valid || sim_active) begin
            unique case (out_fn_type'(out_fn_r))
                OUT_GEN_ALARM: signal_r <= |error_flags;
                OUT_EMPTY_PIPE: signal_r <= empty_pipe_en &
                                            empty_pipe_det;
                OUT_DIRECTION: signal_r <= flow_reverse;
                OUT_NONE: signal_r <= 1'b0;
                OUT_UPPER: signal_r <= out_flow > upper_r;
                OUT_LOWER: signal_r <= out_flow < lower_r;
                OUT_WINDOW: begin
                    if (upper_r < lower_r) begin
                        signal_r <= out_flow > upper_r &&
                                    out_flow < lower_r;
                    end else begin
                        signal_r <= out_flow > upper_r ||
                                    out_flow < lower_r;
                    end
                end
                default: signal_r <= 1'b0;
            endcase
        end
    end

    // Sense only applies to the alarm-type functions
    assign alarm_type = out_fn_r != OUT_DIRECTION && out_fn_r != OUT_NONE;

    // Contact closed = 1; contact test mode overrides the function
    always_comb begin
        if (chk_r == CHK_CONTACT) begin
            switch_contact_output = toggle_r;
        end else if (out_fn_r == OUT_NONE) begin
            switch_contact_output = 1'b0;
        end else if (alarm_type && nc_r) begin
            switch_contact_output = ~signal_r;
        end else begin
            switch_contact_output = signal_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Contact input functions
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            in_prev_r <= 1'b0;
        end else begin
            in_prev_r <= contact_input;
        end
    end

    // Reset fires once on the rising edge, not while held
    assign tot_clear = in_fn_r == IN_TOT_RESET &&
                       contact_input && !in_prev_r;
    assign stop_display = in_fn_r == IN_TOT_STOP && contact_input;
    assign outputs_off = in_fn_r == IN_ZERO_RETURN &&
                         contact_input;
    assign empty_pipe_error = empty_pipe_en & empty_pipe_det;
    assign current_alarm = empty_pipe_error;
    assign tot_halt = stop_display | empty_pipe_error;
    assign outputs_detached = chk_r != CHK_IDLE && !sim_active;

    ////////////////////////////////////////////////////////////////////////
    // Read back
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else begin
            unique case (wb_adr_i)
                REG_OUT_CFG: wb_dat_o <= {27'h0, nc_r, 1'b0, out_fn_r};
                REG_IN_CFG: wb_dat_o <= {30'h0, in_fn_r};
                REG_UPPER: wb_dat_o <= 32'(upper_r);
                REG_LOWER: wb_dat_o <= 32'(lower_r);
                REG_CHECK: wb_dat_o <= {30'h0, chk_r};
                REG_SIM: wb_dat_o <= {24'h0, sim_r};
                REG_STATUS: wb_dat_o <= {26'h0, toggle_r, tot_halt,
                                         outputs_off, contact_input,
                                         switch_contact_output, signal_r};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Checks
    nc_invert_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        chk_r != CHK_CONTACT && alarm_type && nc_r
        |-> switch_contact_output == !signal_r)
        else $error("contact sense wrong");
    none_quiet_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        chk_r != CHK_CONTACT && out_fn_r == OUT_NONE
        |-> !switch_contact_output)
        else $error("contact active with no function");
    upper_cmp_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        flow_valid && !sim_active && out_fn_r == OUT_UPPER
        |=> signal_r == ($past(flow_rate) > $past(upper_r)))
        else $error("upper limit wrong");
    lower_cmp_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        flow_valid && !sim_active && out_fn_r == OUT_LOWER
        |=> signal_r == ($past(flow_rate) < $past(lower_r)))
        else $error("lower limit wrong");
    gen_alarm_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        flow_valid && out_fn_r == OUT_GEN_ALARM
        |=> signal_r == |$past(error_flags))
        else $error("general alarm wrong");
    pulse_width_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        chk_r == CHK_PULSE && pcnt_r == 32'(WIDTH_CYC)
        |-> !test_pulse ##1 !test_pulse)
        else $error("pulse test width wrong");
    cancel_idle_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr && wb_adr_i == REG_CHECK && wb_dat_i[CHK_CANCEL_BIT]
        |=> chk_r == CHK_IDLE && !outputs_detached)
        else $error("cancel did not end check");
    clear_once_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        tot_clear |=> !tot_clear)
        else $error("totalizer clear repeated");
    hart_stop_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        HART_VARIANT |-> in_fn_r != IN_TOT_STOP)
        else $error("stop allowed in HART build");
    ignore_in_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        in_fn_r == IN_NONE |-> !tot_clear && !outputs_off && !stop_display)
        else $error("input not ignored");

    window_cv: cover property (@(posedge clk_sys) disable iff (rst)
        out_fn_r == OUT_WINDOW && upper_r < lower_r && signal_r);
    toggle_cv: cover property (@(posedge clk_sys) disable iff (rst)
        chk_r == CHK_CONTACT && toggle_r);
    pulse_cv: cover property (@(posedge clk_sys) disable iff (rst)
        $fell(test_pulse));
    clear_cv: cover property (@(posedge clk_sys) disable iff (rst)
        tot_clear);

endmodule

`default_nettype wire

// file: dv/field_contacts.sv
// Purpose: Field equipment model wired to the contact terminals.
// Assumes: A dry contact on the input, a relay counter on the output.
// Notes: The lag argument lets scenarios switch promptly or late.
`timescale 1ns/10ps
`default_nettype none

module field_contacts (
    // Clock
    input wire logic clk_sys,
    // Contact terminals
    input wire logic switch_contact_output,
    output logic contact_input
);
    int closures; // Closures seen by the field relay counter

    ////////////////////////////////////////////////////////////////////////
    // Input starts released; an open dry contact reads as inactive
    initial begin
        contact_input = 1'b0;
        closures = 0;
    end

    // Count closures as a relay counter would, no filtering
    always @(posedge switch_contact_output) begin
        closures++;
    end

    // Switch the input a whole number of cycles later, on an edge
    task automatic drive(input logic lvl, input int lag);
        repeat (lag) @(posedge clk_sys);
        contact_input <= lvl;
    endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench for the contact function unit.
// Assumes: Short pulse test counts, 10 cycle period, 5 cycle width.
// Notes: Contact is checked one cycle after the sample is taken.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import contact_io_pkg::*;
    logic clk_sys, rst, cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic ack, flow_valid, flow_reverse, empty_pipe_en, empty_pipe_det;
    logic signed [15:0] flow_rate, out_flow;
    logic [11:0] error_flags;
    logic contact_input, switch_contact_output, current_alarm;
    logic outputs_off, outputs_detached, tot_halt, tot_clear;
    logic stop_display, empty_pipe_error, test_pulse, sim_active;
    logic pl; // Pulse line at the previous sample, for rise counting
    int errors, n_tests, n_clr, cnt, rises, c0;

    contact_io_unit #(.FLOW_W(16), .PERIOD_CYC(10), .WIDTH_CYC(5),
        .HART_VARIANT(1'b0)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .flow_valid(flow_valid), .flow_rate(flow_rate),
        .flow_reverse(flow_reverse), .error_flags(error_flags),
        .empty_pipe_en(empty_pipe_en), .empty_pipe_det(empty_pipe_det),
        .contact_input(contact_input),
        .switch_contact_output(switch_contact_output),
        .current_alarm(current_alarm), .outputs_off(outputs_off),
        .outputs_detached(outputs_detached), .tot_halt(tot_halt),
        .tot_clear(tot_clear), .stop_display(stop_display),
        .empty_pipe_error(empty_pipe_error), .test_pulse(test_pulse),
        .sim_active(sim_active), .out_flow(out_flow));

    field_contacts i_field (.clk_sys(clk_sys),
        .switch_contact_output(switch_contact_output),
        .contact_input(contact_input));

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Clear pulses counted here, since they last a single cycle
    always @(posedge clk_sys) begin
        if (tot_clear === 1'b1) n_clr++;
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #400_000;
        errors++;
        finish_test();
    end

    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // One classic cycle; waits for ack, then releases for a cycle
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // No cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, d_zero(), q);
        chk(q, e);
    endtask

    function automatic logic [31:0] d_zero();
        return 32'h0;
    endfunction

    // Select a function, feed one sample, look one cycle after it lands
    task automatic out_case(input logic [2:0] fn, input logic nc,
        input logic signed [15:0] f, input logic e);
        wr(REG_OUT_CFG, {27'h0, nc, 1'b0, fn});
        @(posedge clk_sys);
        flow_valid <= 1'b1;
        flow_rate <= f;
        @(posedge clk_sys);
        flow_valid <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({31'h0, switch_contact_output}, {31'h0, e});
    endtask

    // Activate the contact input under one function, then release it
    task automatic in_case(input logic [1:0] fn, input logic [2:0] e,
        input int clr);
        wr(REG_IN_CFG, {30'h0, fn});
        n_clr = 0;
        i_field.drive(1'b1, 2);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({29'h0, outputs_off, tot_halt, stop_display}, {29'h0, e});
        chk(n_clr, clr);
        i_field.drive(1'b0, 1);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic finish_test();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, cyc, stb, we, flow_valid, flow_reverse} = 6'h20;
        {empty_pipe_en, empty_pipe_det} = 2'h0;
        adr = 8'h0;
        sel = 4'hf;
        wdat = 32'h0;
        flow_rate = 16'sd0;
        error_flags = 12'h0;
        errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(REG_OUT_CFG, 32'h3);
        rd(REG_IN_CFG, 32'h3);
        rd(8'h1c, 32'h0);
        chk({31'h0, switch_contact_output}, 32'h0);
        wr(REG_UPPER, 32'd60);
        wr(REG_LOWER, 32'd20);
        out_case(OUT_UPPER, 1'b0, 16'sd70, 1'b1);
        out_case(OUT_UPPER, 1'b0, 16'sd50, 1'b0);
        out_case(OUT_UPPER, 1'b1, 16'sd70, 1'b0);
        out_case(OUT_UPPER, 1'b1, 16'sd50, 1'b1);
        out_case(OUT_LOWER, 1'b0, 16'sd10, 1'b1);
        out_case(OUT_LOWER, 1'b0, 16'sd50, 1'b0);
        out_case(OUT_WINDOW, 1'b0, 16'sd70, 1'b1);
        out_case(OUT_WINDOW, 1'b0, 16'sd10, 1'b1);
        out_case(OUT_WINDOW, 1'b0, 16'sd40, 1'b0);
        // Upper below lower turns the window inside out
        wr(REG_UPPER, 32'd20);
        wr(REG_LOWER, 32'd80);
        out_case(OUT_WINDOW, 1'b0, 16'sd50, 1'b1);
        out_case(OUT_WINDOW, 1'b0, 16'sd90, 1'b0);
        out_case(OUT_WINDOW, 1'b0, 16'sd10, 1'b0);
        flow_reverse <= 1'b1;
        out_case(OUT_DIRECTION, 1'b0, -16'sd30, 1'b1);
        flow_reverse <= 1'b0;
        out_case(OUT_DIRECTION, 1'b0, 16'sd30, 1'b0);
        error_flags <= 12'h800;
        out_case(OUT_GEN_ALARM, 1'b0, 16'sd30, 1'b1);
        out_case(OUT_GEN_ALARM, 1'b1, 16'sd30, 1'b0);
        error_flags <= 12'h001;
        out_case(OUT_GEN_ALARM, 1'b0, 16'sd30, 1'b1);
        error_flags <= 12'hfff;
        out_case(OUT_NONE, 1'b1, 16'sd90, 1'b0);
        out_case(3'h7, 1'b0, 16'sd90, 1'b0);
        error_flags <= 12'h0;
        out_case(OUT_GEN_ALARM, 1'b0, 16'sd30, 1'b0);
        // Detector off must hide a detected empty pipe
        empty_pipe_det <= 1'b1;
        out_case(OUT_EMPTY_PIPE, 1'b0, 16'sd30, 1'b0);
        chk({31'h0, current_alarm}, 32'h0);
        empty_pipe_en <= 1'b1;
        out_case(OUT_EMPTY_PIPE, 1'b0, 16'sd30, 1'b1);
        chk({current_alarm, tot_halt, empty_pipe_error}, 3'h7);
        {empty_pipe_en, empty_pipe_det} <= 2'h0;
        out_case(OUT_NONE, 1'b0, 16'sd10, 1'b0);
        in_case(IN_ZERO_RETURN, 3'h4, 0);
        in_case(IN_TOT_RESET, 3'h0, 1);
        in_case(IN_TOT_STOP, 3'h3, 0);
        in_case(IN_NONE, 3'h0, 0);
        // Pulse test: two periods hold 10 high cycles and 2 rises
        wr(REG_CHECK, 32'h1);
        {cnt, rises} = 0;
        // The test opens on a high phase, so that start is no rise
        pl = test_pulse;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            #1;
            cnt += test_pulse;
            rises += (test_pulse && !pl);
            pl = test_pulse;
        end
        chk(cnt, 10);
        chk(rises, 2);
        chk({31'h0, outputs_detached}, 32'h1);
        wr(REG_CHECK, 32'h0);
        chk({31'h0, outputs_detached}, 32'h1);
        wr(REG_CHECK, 32'h10);
        @(posedge clk_sys);
        #1;
        chk({31'h0, outputs_detached}, 32'h0);
        // Contact test toggles per key write, cancel returns it to the selected function, here none, so open
        c0 = i_field.closures;
        wr(REG_CHECK, 32'h3);
        for (int k = 0; k < 3; k++) begin
            wr(REG_CHECK, 32'h20);
            @(posedge clk_sys);
            #1;
            chk({31'h0, switch_contact_output}, 32'(k % 2 == 0));
        end
        wr(REG_CHECK, 32'h10);
        @(posedge clk_sys);
        #1;
        chk({31'h0, switch_contact_output}, 32'h0);
        chk(i_field.closures - c0, 2);
        // Simulated 45 % is above the upper setpoint of 20 %
        wr(REG_OUT_CFG, {29'h0, OUT_UPPER});
        wr(REG_SIM, 32'h2d);
        wr(REG_CHECK, 32'h2);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({sim_active, switch_contact_output}, 2'h3);
        chk({16'h0, out_flow}, 32'h002d);
        wr(REG_SIM, 32'hfb);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({16'h0, out_flow}, 32'hfffb);
        wr(REG_CHECK, 32'h10);
        finish_test();
    end
endmodule
`default_nettype wire
